//--- rtl/pdse_host_ctrl.sv
// pdse_host_ctrl: two-wire master that reads and writes the module's
// presence-detect store, one command at a time
// assumes open-drain scl and sda with pull-ups, and the store strapped
// to the address given with each command
`timescale 1ns/1ps
`include "pdse_defs.svh"
module pdse_host_ctrl
  import pdse_pkg::*;
#(
  parameter int WRC_CYC  = `PDSE_WRC_CYC,  // program cycle wait
  parameter int PAGE_MAX = `PDSE_PAGE_MAX  // bytes per page write
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire pdse_cmd_t              cmd_op,
  input  wire logic                   cmd_prot,
  input  wire logic [2:0]             cmd_strap,
  input  wire logic [7:0]             cmd_addr,
  input  wire logic [`PDSE_LEN_W-1:0] cmd_len,
  input  wire logic                   wr_valid,
  output logic                        wr_ready,
  input  wire logic [7:0]             wr_data,
  output logic                        rd_valid,
  output logic [7:0]                  rd_data,
  output logic                        rd_last,
  output logic                        done,
  output logic                        ack_err,
  output logic                        write_control_pin,
  input  wire logic                   scl_i,
  output logic                        scl_o,
  output logic                        scl_oe,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe
);
  localparam int WRC_W = $clog2(WRC_CYC + 1);
  localparam int LW    = `PDSE_LEN_W;

  // refuse settings the counters cannot hold
  if (WRC_CYC < 1 || PAGE_MAX < 1 || PAGE_MAX > `PDSE_PAGE_MAX) begin
    : g_bad_param
    $error("pdse_host_ctrl: parameter out of range");
  end

  // all controller state
  typedef struct packed {
    pdse_st_t         st;    // byte-level state
    pdse_stg_t        stg;   // byte of the sequence
    pdse_cmd_t        op;    // command in work
    logic             pend;  // bit request outstanding
    logic [2:0]       bitn;  // bit index in byte
    logic [7:0]       sh;    // shift register
    logic [LW-1:0]    left;  // data bytes still to move
    logic [3:0]       dtype; // select type identifier
    logic [2:0]       strap; // strapped address
    logic [7:0]       addr;  // word address
    logic             err;   // last command failed
    logic             done;  // command finished pulse
    logic             rdv;   // read byte pulse
    logic [7:0]       rdd;   // read byte
    logic             rdl;   // read byte is last
    logic             wctl_n; // write control level, low to write
    logic [WRC_W-1:0] wrc;   // program cycle timer
  } pdse_main_t;

  localparam pdse_main_t M_RST = '{st: PDSE_M_IDLE, stg: PDSE_G_DEV,
                                  op: PDSE_CMD_CUR_RD, wctl_n: 1'b1,
                                  default: '0};
  pdse_main_t q, d;
  pdse_bit_if bus ();
  logic       bad_len; // length the command cannot carry
  logic       last;    // current byte is the final one

  // bit engine drives the wires
  pdse_bit_engine u_eng (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .bus     (bus),
    .scl_i   (scl_i),
    .scl_o   (scl_o),
    .scl_oe  (scl_oe),
    .sda_i   (sda_i),
    .sda_o   (sda_o),
    .sda_oe  (sda_oe)
  );

  assign bad_len = (cmd_len == '0) ||
                   (cmd_op == PDSE_CMD_WRITE &&
                    cmd_len > LW'(PAGE_MAX));
  assign last    = (q.left == LW'(1));

  // bit requests follow the state; one outstanding at a time
  always_comb begin
    bus.req  = 1'b0;
    bus.op   = PDSE_OP_BIT;
    bus.wbit = 1'b1;
    unique case (q.st)
      PDSE_M_START: begin
        bus.req = !q.pend;
        bus.op  = PDSE_OP_START;
      end
      PDSE_M_STOP: begin
        bus.req = !q.pend;
        bus.op  = PDSE_OP_STOP;
      end
      PDSE_M_TXBIT: begin
        bus.req  = !q.pend;
        bus.wbit = q.sh[7];
      end
      PDSE_M_TXACK, PDSE_M_RXBIT: begin
        bus.req = !q.pend;
      end
      PDSE_M_RXACK: begin
        bus.req  = !q.pend;
        bus.wbit = last;
      end
      default: bus.req = 1'b0;
    endcase
  end

  // next state of the controller
  always_comb begin
    d      = q;
    d.done = 1'b0;
    d.rdv  = 1'b0;
    if (bus.req) begin
      d.pend = 1'b1;
    end
    if (bus.done) begin
      d.pend = 1'b0;
    end
    unique case (q.st)
      PDSE_M_IDLE: begin
        // take a command; bad lengths fail at once
        if (cmd_valid) begin
          d.err = bad_len;
          if (bad_len) begin
            d.done = 1'b1;
          end else begin
            d.op    = cmd_op;
            d.dtype = cmd_prot ? `PDSE_TYPE_PROT
                               : `PDSE_TYPE_MEM;
            d.strap = cmd_strap;
            d.addr  = cmd_addr;
            d.left  = cmd_len;
            d.stg   = PDSE_G_DEV;
            d.wctl_n = (cmd_op != PDSE_CMD_WRITE);
            d.st    = PDSE_M_START;
          end
        end
      end
      PDSE_M_START: begin
        // load select byte; direction by stage and command
        if (bus.done) begin
          d.sh   = {q.dtype, q.strap,
                    (q.stg == PDSE_G_DEV2 || q.op == PDSE_CMD_CUR_RD)
                    ? `PDSE_DIR_RD : `PDSE_DIR_WR};
          d.bitn = '0;
          d.st   = PDSE_M_TXBIT;
        end
      end
      PDSE_M_TXBIT: begin
        // shift out msb first
        if (bus.done) begin
          d.sh   = {q.sh[6:0], 1'b0};
          d.bitn = q.bitn + 3'h1;
          if (q.bitn == `PDSE_BIT_LAST) begin
            d.st = PDSE_M_TXACK;
          end
        end
      end
      PDSE_M_TXACK: begin
        // slave answer in the ninth clock
        if (bus.done) begin
          d.bitn = '0;
          if (bus.rbit) begin
            // no answer: busy, absent or protected
            d.err = 1'b1;
            d.st  = PDSE_M_STOP;
          end else begin
            unique case (q.stg)
              PDSE_G_DEV: begin
                if (q.op == PDSE_CMD_CUR_RD) begin
                  d.st = PDSE_M_RXBIT;
                end else begin
                  d.stg = PDSE_G_ADDR;
                  d.sh  = q.addr;
                  d.st  = PDSE_M_TXBIT;
                end
              end
              PDSE_G_ADDR: begin
                if (q.op == PDSE_CMD_RAND_RD) begin
                  d.stg = PDSE_G_DEV2;
                  d.st  = PDSE_M_START;
                end else begin
                  d.stg = PDSE_G_DATA;
                  d.st  = PDSE_M_FETCH;
                end
              end
              PDSE_G_DEV2: begin
                d.st = PDSE_M_RXBIT;
              end
              PDSE_G_DATA: begin
                d.left = q.left - LW'(1);
                d.st   = last ? PDSE_M_STOP : PDSE_M_FETCH;
              end
            endcase
          end
        end
      end
      PDSE_M_FETCH: begin
        // wait for the next write byte from the user
        if (wr_valid) begin
          d.sh   = wr_data;
          d.bitn = '0;
          d.st   = PDSE_M_TXBIT;
        end
      end
      PDSE_M_RXBIT: begin
        // shift in msb first
        if (bus.done) begin
          d.sh   = {q.sh[6:0], bus.rbit};
          d.bitn = q.bitn + 3'h1;
          if (q.bitn == `PDSE_BIT_LAST) begin
            d.st = PDSE_M_RXACK;
          end
        end
      end
      PDSE_M_RXACK: begin
        // hand the byte over; nack the last one
        if (bus.done) begin
          d.rdv  = 1'b1;
          d.rdd  = q.sh;
          d.rdl  = last;
          d.left = q.left - LW'(1);
          d.bitn = '0;
          d.st   = last ? PDSE_M_STOP : PDSE_M_RXBIT;
        end
      end
      PDSE_M_STOP: begin
        // end of transfer; a good write starts the program wait
        if (bus.done) begin
          d.done = 1'b1;
          d.wctl_n = 1'b1;
          if (q.op == PDSE_CMD_WRITE && !q.err) begin
            d.wrc = WRC_W'(WRC_CYC - 1);
            d.st  = PDSE_M_WRC;
          end else begin
            d.st = PDSE_M_IDLE;
          end
        end
      end
      PDSE_M_WRC: begin
        // no traffic until the program cycle is over
        d.wrc = q.wrc - WRC_W'(1);
        if (q.wrc == '0) begin
          d.st = PDSE_M_IDLE;
        end
      end
      default: d.st = PDSE_M_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= M_RST;
    end else begin
      q <= d;
    end
  end

  assign cmd_ready         = (q.st == PDSE_M_IDLE);
  assign wr_ready          = (q.st == PDSE_M_FETCH);
  assign rd_valid          = q.rdv;
  assign rd_data           = q.rdd;
  assign rd_last           = q.rdl;
  assign done              = q.done;
  assign ack_err           = q.err;
  assign write_control_pin = q.wctl_n;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  dev_type_a: assert property (
    (q.st == PDSE_M_TXBIT && q.stg != PDSE_G_ADDR &&
     q.stg != PDSE_G_DATA && q.bitn == 3'h0 && bus.req)
    |-> q.sh[7:4] == `PDSE_TYPE_MEM || q.sh[7:4] == `PDSE_TYPE_PROT)
    else $error("select byte carries a wrong type");
  dev_dir_a: assert property (
    (q.st == PDSE_M_START && bus.done) |=>
      q.sh[0] == (q.stg == PDSE_G_DEV2 || q.op == PDSE_CMD_CUR_RD))
    else $error("select byte carries a wrong direction");
  ack_release_a: assert property (
    (q.st == PDSE_M_TXACK && bus.req) |-> bus.wbit)
    else $error("master held sda in the slave ack slot");
  master_ack_a: assert property (
    (q.st == PDSE_M_RXACK && bus.req) |-> bus.wbit == last)
    else $error("master ack level wrong for read byte");
  wctl_low_a: assert property (
    (q.st == PDSE_M_FETCH || q.stg == PDSE_G_DATA &&
     q.st == PDSE_M_TXBIT) |-> !write_control_pin)
    else $error("write data sent with write control high");
  page_max_a: assert property (
    (q.st != PDSE_M_IDLE && q.op == PDSE_CMD_WRITE)
    |-> q.left <= LW'(PAGE_MAX))
    else $error("page write longer than allowed");
  wrc_hold_a: assert property (
    (q.st == PDSE_M_STOP && bus.done && q.op == PDSE_CMD_WRITE &&
     !q.err) |=> !cmd_ready [*8])
    else $error("command taken during program cycle");
  start_first_a: assert property (
    (cmd_ready && cmd_valid && !bad_len) |=>
      q.st == PDSE_M_START && bus.req && bus.op == PDSE_OP_START)
    else $error("command did not open with a start");
  stop_done_a: assert property (
    (q.st == PDSE_M_STOP && bus.done) |=> done)
    else $error("stop did not finish the command");

  write_ok_c: cover property (
    q.st == PDSE_M_STOP && bus.done && q.op == PDSE_CMD_WRITE && !q.err);
  seq_read_c: cover property (rd_valid && !rd_last);
  nack_c:     cover property ($rose(ack_err));
endmodule : pdse_host_ctrl

//--- rtl/pdse_defs.svh
// pdse_defs.svh: constants of the presence-detect eeprom host controller
// assumes a 200 MHz system clock; included by bare name
`ifndef PDSE_DEFS_SVH
`define PDSE_DEFS_SVH
`define PDSE_CLK_NS       5
`define PDSE_CYC_UP(ns)   (((ns) + `PDSE_CLK_NS - 1) / `PDSE_CLK_NS)
`define PDSE_T_LOW_NS     1300
`define PDSE_T_HIGH_NS    600
`define PDSE_T_SU_STA_NS  600
`define PDSE_T_HD_STA_NS  600
`define PDSE_T_SU_STO_NS  600
`define PDSE_T_BUF_NS     1300
`define PDSE_T_DH_NS      200
`define PDSE_T_WRC_MS     10
`define PDSE_WRC_CYC      (`PDSE_T_WRC_MS * 1000000 / `PDSE_CLK_NS)
`define PDSE_CNT_W        9
`define PDSE_TYPE_MEM     4'ha
`define PDSE_TYPE_PROT    4'h6
`define PDSE_PAGE_MAX     16
`define PDSE_LEN_W        5
`define PDSE_DIR_RD       1'b1
`define PDSE_DIR_WR       1'b0
`define PDSE_BIT_LAST     3'h7
`endif

//--- rtl/pdse_pkg.sv
// pdse_pkg: types shared by the host controller and its bit engine
// assumes nothing beyond a SystemVerilog compiler
package pdse_pkg;
  // bit-level operations asked of the engine
  typedef enum logic [1:0] {
    PDSE_OP_START = 2'b00,
    PDSE_OP_STOP  = 2'b01,
    PDSE_OP_BIT   = 2'b10
  } pdse_op_t;
  // engine phases: low, wait line high, high, trailing
  typedef enum logic [2:0] {
    PDSE_PH_IDLE = 3'b000,
    PDSE_PH_A    = 3'b001,
    PDSE_PH_B    = 3'b010,
    PDSE_PH_C    = 3'b011,
    PDSE_PH_D    = 3'b100
  } pdse_ph_t;
  // user commands
  typedef enum logic [1:0] {
    PDSE_CMD_CUR_RD  = 2'b00,
    PDSE_CMD_RAND_RD = 2'b01,
    PDSE_CMD_WRITE   = 2'b10
  } pdse_cmd_t;
  // byte-level controller states
  typedef enum logic [3:0] {
    PDSE_M_IDLE  = 4'b0000,
    PDSE_M_START = 4'b0001,
    PDSE_M_TXBIT = 4'b0010,
    PDSE_M_TXACK = 4'b0011,
    PDSE_M_RXBIT = 4'b0100,
    PDSE_M_RXACK = 4'b0101,
    PDSE_M_FETCH = 4'b0110,
    PDSE_M_STOP  = 4'b0111,
    PDSE_M_WRC   = 4'b1000
  } pdse_st_t;
  // which byte of the sequence is on the wire
  typedef enum logic [1:0] {
    PDSE_G_DEV  = 2'b00,
    PDSE_G_ADDR = 2'b01,
    PDSE_G_DEV2 = 2'b10,
    PDSE_G_DATA = 2'b11
  } pdse_stg_t;
endpackage : pdse_pkg

//--- rtl/pdse_bit_if.sv
// pdse_bit_if: request and answer between byte controller and bit engine
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface pdse_bit_if;
  import pdse_pkg::*;
  logic     req;   // one-cycle request, taken when the engine is idle
  pdse_op_t op;    // operation requested
  logic     wbit;  // bit to send, 1 releases sda
  logic     done;  // one-cycle pulse, operation finished
  logic     rbit;  // sda sampled in the high phase
  modport ctl (output req, output op, output wbit,
               input done, input rbit);
  modport eng (input req, input op, input wbit,
               output done, output rbit);
endinterface : pdse_bit_if

//--- rtl/pdse_bit_engine.sv
// pdse_bit_engine: makes start, stop and single bit frames on the wires
// assumes open-drain pins with pull-ups; scl_i and sda_i are asynchronous
`timescale 1ns/1ps
`include "pdse_defs.svh"
module pdse_bit_engine
  import pdse_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  pdse_bit_if.eng   bus,
  input  wire logic scl_i,
  output logic      scl_o,
  output logic      scl_oe,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe
);
  localparam logic [8:0] T_LOW = 9'(`PDSE_CYC_UP(`PDSE_T_LOW_NS));
  localparam logic [8:0] T_HI  = 9'(`PDSE_CYC_UP(`PDSE_T_HIGH_NS));
  localparam logic [8:0] T_SUA = 9'(`PDSE_CYC_UP(`PDSE_T_SU_STA_NS));
  localparam logic [8:0] T_HDA = 9'(`PDSE_CYC_UP(`PDSE_T_HD_STA_NS));
  localparam logic [8:0] T_SUO = 9'(`PDSE_CYC_UP(`PDSE_T_SU_STO_NS));
  localparam logic [8:0] T_BUF = 9'(`PDSE_CYC_UP(`PDSE_T_BUF_NS));
  localparam logic [8:0] T_DH  = 9'(`PDSE_CYC_UP(`PDSE_T_DH_NS));

  // all engine state
  typedef struct packed {
    logic                   scl_m;   // synchroniser first stage
    logic                   scl_s;   // synchronised scl
    logic                   sda_m;   // synchroniser first stage
    logic                   sda_s;   // synchronised sda
    pdse_ph_t               ph;      // phase
    pdse_op_t               op;      // operation in work
    logic                   wbit;    // bit to send
    logic [`PDSE_CNT_W-1:0] cnt;     // phase timer
    logic                   scl_oe;  // pulling scl low
    logic                   sda_oe;  // pulling sda low
    logic                   done;    // finish pulse
    logic                   rbit;    // sampled sda
  } pdse_eng_t;

  localparam pdse_eng_t E_RST = '{ph: PDSE_PH_IDLE, op: PDSE_OP_START,
                                  default: '0};
  pdse_eng_t q, d;

  // next state of the engine
  always_comb begin
    d       = q;
    d.scl_m = scl_i;
    d.scl_s = q.scl_m;
    d.sda_m = sda_i;
    d.sda_s = q.sda_m;
    d.done  = 1'b0;
    unique case (q.ph)
      PDSE_PH_IDLE: begin
        // take a request; scl level is kept as it stands
        if (bus.req) begin
          d.op   = bus.op;
          d.wbit = bus.wbit;
          d.cnt  = '0;
          d.ph   = PDSE_PH_A;
        end
      end
      PDSE_PH_A: begin
        // scl low: sda moves only after a hold time
        d.cnt = q.cnt + 9'h001;
        if (q.cnt == T_DH) begin
          d.sda_oe = (q.op == PDSE_OP_STOP) ||
                     (q.op == PDSE_OP_BIT && !q.wbit);
        end
        if (q.cnt == T_LOW) begin
          d.scl_oe = 1'b0;
          d.ph     = PDSE_PH_B;
        end
      end
      PDSE_PH_B: begin
        // wait for the line to reach high, a slave may stretch
        if (q.scl_s) begin
          d.cnt = '0;
          d.ph  = PDSE_PH_C;
        end
      end
      PDSE_PH_C: begin
        // scl high; sample data at its end
        d.cnt = q.cnt + 9'h001;
        if ((q.op == PDSE_OP_BIT && q.cnt == T_HI) ||
            (q.op == PDSE_OP_START && q.cnt == T_SUA) ||
            (q.op == PDSE_OP_STOP && q.cnt == T_SUO)) begin
          d.rbit = q.sda_s;
          d.cnt  = '0;
          if (q.op == PDSE_OP_BIT) begin
            d.scl_oe = 1'b1;
            d.done   = 1'b1;
            d.ph     = PDSE_PH_IDLE;
          end else begin
            d.sda_oe = (q.op == PDSE_OP_START);
            d.ph     = PDSE_PH_D;
          end
        end
      end
      PDSE_PH_D: begin
        // start hold, or bus free time after stop
        d.cnt = q.cnt + 9'h001;
        if ((q.op == PDSE_OP_START && q.cnt == T_HDA) ||
            (q.op == PDSE_OP_STOP && q.cnt == T_BUF)) begin
          d.scl_oe = (q.op == PDSE_OP_START);
          d.done   = 1'b1;
          d.ph     = PDSE_PH_IDLE;
        end
      end
      default: d.ph = PDSE_PH_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= E_RST;
    end else begin
      q <= d;
    end
  end

  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe   = q.scl_oe;
  assign sda_oe   = q.sda_oe;
  assign bus.done = q.done;
  assign bus.rbit = q.rbit;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sda_stable_a: assert property (
    (!q.scl_oe && $changed(q.sda_oe)) |-> q.ph == PDSE_PH_D)
    else $error("sda moved while scl high outside start or stop");
  start_edge_a: assert property (
    ($rose(q.sda_oe) && !q.scl_oe) |-> q.op == PDSE_OP_START)
    else $error("sda fell with scl high but no start");
  stop_edge_a: assert property (
    ($fell(q.sda_oe) && !q.scl_oe) |-> q.op == PDSE_OP_STOP ##1
      !q.sda_oe [*8])
    else $error("sda rose with scl high but no stop");
endmodule : pdse_bit_engine

//--- verification/pdse_eeprom_model.sv
// pdse_eeprom_model: behavioural presence-detect store on the two wires
// assumes open-drain wires resolved by the bench with pull-ups on both
`timescale 1ns/1ps
module pdse_eeprom_model #(
  parameter logic [2:0] STRAP  = 3'h5,  // strapped address bits
  parameter int         WRC_NS = 200    // program cycle, kept short
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic write_control_pin,
  output logic      sda_oe
);
  logic [7:0] mem [256];  // array contents
  logic [7:0] sh;         // receive shifter
  logic [7:0] ptr;        // internal address pointer
  logic [7:0] pv;         // protection register
  logic       act;        // selected and listening
  logic       pr;         // protection register selected
  logic       wr;         // a byte was written in this sequence
  int         bc;         // bit count within the byte
  int         stg;        // 0 select 1 addr 2 write 3 read 4 read ack
  realtime    t_end;      // end of the program cycle
  realtime    t_sclr;     // last rise of scl, for glitch rejection
  // array starts with the inverse of each address
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = ~i[7:0];
    act = 0;
    sda_oe = 0;
    t_end = 0;
    pv = 8'h00;
    ptr = 8'h00;
    wr = 0;
  end
  // remember when scl rose; start and stop need it high 50 ns first
  always @(posedge scl) t_sclr = $realtime;
  // start: sda falls while scl high
  always @(negedge sda)
    if (scl === 1'b1 && $realtime - t_sclr >= 50) begin
    act = 1;
    bc = 0;
    stg = 0;
  end
  // stop: sda rises while scl high; a write starts the program cycle
  always @(posedge sda)
    if (scl === 1'b1 && $realtime - t_sclr >= 50) begin
    if (wr) t_end = $realtime + WRC_NS;
    wr = 0;
    act = 0;
    sda_oe = 0;
  end
  // sample on the rising clock edge
  always @(posedge scl) if (act) begin
    if (bc < 8) begin
      sh = {sh[6:0], sda};
      bc++;
    end else begin
      bc = 0;
      if (stg == 3) ptr++;
      if (stg == 3 && sda) act = 0;
      if (stg == 4) stg = 3;
    end
  end
  // drive on the falling clock edge
  always @(negedge scl) if (act) begin
    sda_oe = 0;
    if (bc == 8 && stg == 0) begin
      pr = sh[7:4] == 4'h6;
      if (sh[3:1] == STRAP && (pr || sh[7:4] == 4'ha) &&
          $realtime >= t_end) begin
        sda_oe = 1;
        stg = sh[0] ? 4 : 1;
      end else act = 0;
    end else if (bc == 8 && stg == 1) begin
      ptr = sh;
      sda_oe = 1;
      stg = 2;
    end else if (bc == 8 && stg == 2 && !write_control_pin) begin
      sda_oe = 1;
      wr = 1;
      if (pr) pv = sh;
      else mem[ptr] = sh;
      ptr[3:0] = ptr[3:0] + 4'h1;
    end else if (bc == 8 && stg == 2) act = 0;
    else if (bc < 8 && stg == 3)
      sda_oe = ~(pr ? pv[7-bc] : mem[ptr][7-bc]);
  end
endmodule : pdse_eeprom_model

//--- verification/tb.sv
// tb: runs the host controller against the behavioural store model
// assumes the program wait is shortened to 50 cycles
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module tb
  import pdse_pkg::*;
;
  typedef struct packed {
    pdse_cmd_t  op;
    logic       prot;
    logic [2:0] strap;
    logic [7:0] addr;
    logic [4:0] len;
    logic [7:0] base;  // first data byte, later ones count up
    logic       err;
  } pdse_row_t;
  logic       clk_sys = 0;
  logic       rst_n = 0;
  logic       cmd_valid = 0;
  logic       cmd_prot = 0;
  logic       wr_valid = 0;
  pdse_cmd_t  cmd_op = PDSE_CMD_CUR_RD;
  logic [2:0] cmd_strap = 3'h0;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic [4:0] cmd_len = 5'h00;
  logic       cmd_ready, wr_ready, rd_valid, rd_last, done, ack_err;
  logic       wcp, scl_o, scl_oe, sda_o, sda_oe, m_oe;
  logic [7:0] rd_data;
  wire        scl_w = ~scl_oe;           // pull-up unless pulled low
  wire        sda_w = ~(sda_oe | m_oe);  // wired-and of both ends
  int         n_fail = 0;
  int         tests_run = 0;
  int         nrd;
  int         wi;
  // write wraps in page, reads back, current read, bad strap, protection write, protection read
  pdse_row_t  rows [7] = '{
    '{PDSE_CMD_WRITE,   1'b0, 3'h5, 8'h3e, 5'h03, 8'h11, 1'b0},
    '{PDSE_CMD_RAND_RD, 1'b0, 3'h5, 8'h3e, 5'h02, 8'h11, 1'b0},
    '{PDSE_CMD_RAND_RD, 1'b0, 3'h5, 8'h30, 5'h01, 8'h13, 1'b0},
    '{PDSE_CMD_CUR_RD,  1'b0, 3'h5, 8'h00, 5'h01, 8'hce, 1'b0},
    '{PDSE_CMD_CUR_RD,  1'b0, 3'h2, 8'h00, 5'h01, 8'h00, 1'b1},
    '{PDSE_CMD_WRITE,   1'b1, 3'h5, 8'h00, 5'h01, 8'h77, 1'b0},
    '{PDSE_CMD_CUR_RD,  1'b1, 3'h5, 8'h00, 5'h01, 8'h77, 1'b0}};
  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;
  pdse_host_ctrl #(.WRC_CYC(50), .PAGE_MAX(16)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_prot(cmd_prot),
    .cmd_strap(cmd_strap), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_data(rd_data), .rd_last(rd_last),
    .done(done), .ack_err(ack_err), .write_control_pin(wcp),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
  pdse_eeprom_model #(.STRAP(3'h5), .WRC_NS(200)) model (
    .scl(scl_w), .sda(sda_w), .write_control_pin(wcp), .sda_oe(m_oe));
  // prints counts and verdict, then ends the run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // offers one command, feeds write bytes, checks read bytes
  task automatic run(input pdse_row_t r, input bit ab);
    int k;
    @(negedge clk_sys);
    cmd_op = r.op;
    cmd_prot = r.prot;
    cmd_strap = r.strap;
    cmd_addr = r.addr;
    cmd_len = r.len;
    cmd_valid = 1;
    for (k = 0; k < 200 && cmd_ready !== 1'b1; k++) @(negedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 0;
    nrd = 0;
    wi = 0;
    for (k = 0; k < 60000 && done !== 1'b1; k++) begin
      @(negedge clk_sys);
      if (ab && wr_ready === 1'b1) return;
      if (rd_valid === 1'b1) begin
        `CHK(rd_data, r.base + 8'(nrd))
        `CHK(rd_last, 1'(nrd + 1 == int'(r.len)))
        nrd++;
      end
      if (wr_valid && wr_ready !== 1'b1) begin
        wi++;
        wr_valid = 0;
      end else if (wr_ready === 1'b1) begin
        `CHK(wcp, 1'b0)
        wr_data = r.base + 8'(wi);
        wr_valid = 1;
      end
    end
    `CHK(ack_err, r.err)
    `CHK(nrd, (r.op == PDSE_CMD_WRITE || r.err) ? 0 : int'(r.len))
    if (r.op == PDSE_CMD_WRITE && !r.err) begin
      repeat (2) @(negedge clk_sys);
      `CHK(cmd_ready, 1'b0)
    end
  endtask : run
  // main sequence: reset, table rows, then hand-written cases
  initial begin
    repeat (10) @(negedge clk_sys);
    `CHK({cmd_ready, wcp, scl_oe, sda_oe, ack_err, done}, 6'h30)
    `CHK({scl_o, sda_o}, 2'h0)
    rst_n = 1;
    foreach (rows[i]) begin
      run(rows[i], 1'b0);
      $display("row %0d finished", i);
    end
    run('{PDSE_CMD_WRITE, 1'b0, 3'h5, 8'h00, 5'h11, 8'h00, 1'b1},
        1'b0);
    $display("long write finished");
    run(rows[0], 1'b1);
    rst_n = 0;
    wr_valid = 0;
    @(negedge clk_sys);
    `CHK({scl_oe, sda_oe, cmd_ready}, 3'h1)
    rst_n = 1;
    run(rows[1], 1'b0);
    $display("reset in mid write finished");
    stop_test();
  end
  // watchdog past the expected run of about 110k cycles
  initial begin
    #650000;
    n_fail++;
    stop_test();
  end
endmodule : tb
